/* rtl/cwdt_top.sv */
/*
 * Crystal watchdog timer: free-running counter, interrupt flag,
 * reset flag, processor reset request and register port.
 * Assumes a processor that samples the reset and interrupt requests
 * on ref_clk, and a register master with one-cycle strobes.
 */
`timescale 1ns/10ps
`include "cwdt_defs.svh"

module cwdt_top
	import cwdt_pkg::*;
#(
	parameter int CNT_W  = 27,   // Counter width
	parameter int EXP_00 = 17,   // Interrupt count exponent, select 00
	parameter int EXP_01 = 20,   // Interrupt count exponent, select 01
	parameter int EXP_10 = 23,   // Interrupt count exponent, select 10
	parameter int EXP_11 = 26    // Interrupt count exponent, select 11
)
(
	input  wire logic       ref_clk,        // Crystal clock, 50 MHz
	input  wire logic       sys_rst,        // Synchronous reset, high
	input  wire logic       clk_en,         // Clock enable
	input  wire logic [7:0] reg_addr,       // Register address
	input  wire logic [7:0] reg_wdata,      // Write data
	input  wire logic       reg_wr,         // Write strobe
	input  wire logic       reg_rd,         // Read strobe
	output logic      [7:0] reg_rdata,      // Read data, cycle after
	output logic            wdog_irq,       // Interrupt request
	output logic            wdog_wake,      // Wake from low power
	output logic            wdog_cpu_rst    // Processor reset pulse
);

	// ------------------------------------------------------------
	// Count helpers
	// ------------------------------------------------------------
	// Interrupt count length for a select code
	function automatic logic [CNT_W-1:0] sel_count(input cwdt_sel_t sel);
		logic [CNT_W-1:0] one;
		one = {{(CNT_W-1){1'b0}}, 1'b1};
		unique case (sel)
			2'h0: sel_count = one << EXP_00;
			2'h1: sel_count = one << EXP_01;
			2'h2: sel_count = one << EXP_10;
			2'h3: sel_count = one << EXP_11;
		endcase
	endfunction

	// Gap to the reset flag, at counter width
	localparam logic [CNT_W-1:0] GAP = CNT_W'(`CWDT_RST_GAP);

	// ------------------------------------------------------------
	// Registers and state
	// ------------------------------------------------------------
	logic [CNT_W-1:0] cnt_r;           // Watchdog counter
	logic [CNT_W-1:0] irq_last;        // Last count before irq flag
	logic [CNT_W-1:0] full_last;       // Last count before time-out
	logic [7:0]       clk_speed_r;     // Clock speed control
	logic [7:0]       ext_irq_en_r;    // Extended interrupt enable
	logic             irq_flag_r;      // Watchdog irq flag
	logic             rst_flag_r;      // Watchdog reset flag
	logic             rst_en_r;        // Reset enable
	logic [7:0]       rdata_r;         // Read data
	logic             irq_r;           // Registered irq request
	logic             wake_r;          // Registered wake request
	logic             cpu_rst_r;       // Registered reset pulse
	cwdt_sel_t        sel;             // Current time-out select
	logic             irq_en;          // Watchdog irq enable
	logic             hit_irq;         // Interrupt count reached
	logic             hit_full;        // Full time-out reached
	logic             wr_ta;           // Timed access write
	logic             wr_wdc;          // Watchdog control write
	logic             wr_cks;          // Clock speed write
	logic             wr_eie;          // Interrupt enable write
	logic             win_open;        // Unlock window open
	logic             restart;         // Accepted restart
	logic             clr_irq;         // Software clears irq flag
	logic             clr_rst;         // Software clears reset flag

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	// Select bits at the top of the clock speed register
	assign sel     = {clk_speed_r[`CWDT_BIT_SEL_HI],
	                  clk_speed_r[`CWDT_BIT_SEL_LO]};
	assign irq_en  = ext_irq_en_r[`CWDT_BIT_IRQ_EN];

	// Compare points, both from the same select
	assign irq_last  = sel_count(sel) - {{(CNT_W-1){1'b0}}, 1'b1};
	assign full_last = sel_count(sel) + GAP - {{(CNT_W-1){1'b0}}, 1'b1};

	// Counter positions; >= keeps a shortened select safe
	assign hit_irq  = (cnt_r == irq_last);
	assign hit_full = (cnt_r >= full_last);

	// Write strobes per register
	assign wr_ta  = reg_wr && reg_addr == `CWDT_OFS_TIMED_ACCESS;
	assign wr_wdc = reg_wr && reg_addr == `CWDT_OFS_WDOG_CTRL;
	assign wr_cks = reg_wr && reg_addr == `CWDT_OFS_CLK_SPEED;
	assign wr_eie = reg_wr && reg_addr == `CWDT_OFS_EXT_IRQ_EN;

	// Restart only with the window open
	assign restart = wr_wdc && win_open
	                 && reg_wdata[`CWDT_BIT_RESTART];

	// Flag clears by writing zero, no unlock needed
	assign clr_irq = wr_wdc && !reg_wdata[`CWDT_BIT_IRQ_FLAG];
	assign clr_rst = wr_wdc && !reg_wdata[`CWDT_BIT_RST_FLAG];

	// ------------------------------------------------------------
	// Timed access unlock
	// ------------------------------------------------------------
	cwdt_unlock u_unlock (
		.ref_clk  (ref_clk),
		.sys_rst  (sys_rst),
		.clk_en   (clk_en),
		.wr_any   (reg_wr),
		.ta_wr    (wr_ta),
		.wdata    (reg_wdata),
		.prot_wr  (wr_wdc),
		.win_open (win_open)
	);

	// ------------------------------------------------------------
	// Watchdog counter
	// ------------------------------------------------------------
	// Counts every crystal clock with clk_en high, no enable bit
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			cnt_r <= '0;
		else if (clk_en)
		begin
			if (restart)
				cnt_r <= '0;
			else if (hit_full)
				cnt_r <= '0;
			else
				cnt_r <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
		end
	end

	// ------------------------------------------------------------
	// Status flags
	// ------------------------------------------------------------
	// Irq flag; set wins over a clear in the same cycle
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			irq_flag_r <= 1'b0;
		else if (clk_en)
		begin
			if (hit_irq && !restart)
				irq_flag_r <= 1'b1;
			else if (clr_irq)
				irq_flag_r <= 1'b0;
		end
	end

	// Reset flag; kept across its own processor reset
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			rst_flag_r <= 1'b0;
		else if (clk_en)
		begin
			if (hit_full && !restart)
				rst_flag_r <= 1'b1;
			else if (clr_rst)
				rst_flag_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	// Reset enable behind the unlock
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			rst_en_r <= `CWDT_RST_RST_EN;
		else if (clk_en && wr_wdc && win_open)
			rst_en_r <= reg_wdata[`CWDT_BIT_RST_EN];
	end

	// Clock speed control, select bits and timer rate bits
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			clk_speed_r <= `CWDT_RST_CLK_SPEED;
		else if (clk_en && wr_cks)
			clk_speed_r <= reg_wdata;
	end

	// Extended interrupt enable
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			ext_irq_en_r <= `CWDT_RST_EXT_IRQ_EN;
		else if (clk_en && wr_eie)
			ext_irq_en_r <= reg_wdata;
	end

	// ------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------
	// Data stands only in the cycle after the read strobe
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			rdata_r <= 8'h00;
		else if (clk_en)
		begin
			rdata_r <= 8'h00;
			if (reg_rd)
			begin
				unique case (reg_addr)
					`CWDT_OFS_CLK_SPEED:
						rdata_r <= clk_speed_r;
					`CWDT_OFS_EXT_IRQ_EN:
						rdata_r <= ext_irq_en_r;
					`CWDT_OFS_WDOG_CTRL:
					begin
						// Restart reads as zero
						rdata_r[`CWDT_BIT_IRQ_FLAG] <= irq_flag_r;
						rdata_r[`CWDT_BIT_RST_FLAG] <= rst_flag_r;
						rdata_r[`CWDT_BIT_RST_EN]   <= rst_en_r;
					end
					default:
						rdata_r <= 8'h00;   // Unmapped and key register
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Requests to the processor
	// ------------------------------------------------------------
	// Interrupt request needs flag and enable only
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			irq_r <= 1'b0;
		else if (clk_en)
			irq_r <= irq_flag_r && irq_en;
	end

	// Wake request follows the enabled interrupt
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			wake_r <= 1'b0;
		else if (clk_en)
			wake_r <= irq_flag_r && irq_en;
	end

	// Processor reset pulse, gated by reset enable only
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			cpu_rst_r <= 1'b0;
		else if (clk_en)
			cpu_rst_r <= hit_full && !restart && rst_en_r;
	end

	assign reg_rdata    = rdata_r;
	assign wdog_irq     = irq_r;
	assign wdog_wake    = wake_r;
	assign wdog_cpu_rst = cpu_rst_r;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	// Key sequence written on enabled cycles
	sequence s_key1;
		clk_en && wr_ta && reg_wdata == `CWDT_UNLOCK_KEY1;
	endsequence

	sequence s_key2;
		clk_en && wr_ta && reg_wdata == `CWDT_UNLOCK_KEY2;
	endsequence

	// Interrupt point reached without restart
	sequence s_irq_point;
		clk_en && hit_irq && !restart;
	endsequence

	AST_UNLOCK_OPENS: assert property (s_key1 ##1 s_key2 |=> win_open)
		else $error("unlock keys did not open the window");

	AST_LOCKED_RST_EN: assert property (
		clk_en && wr_wdc && !win_open |=> rst_en_r == $past(rst_en_r))
		else $error("reset enable changed without unlock");

	AST_IRQ_FLAG_SET: assert property (s_irq_point |=> irq_flag_r)
		else $error("irq flag not set at interrupt count");

	// Clocks since the irq point, counted apart from the watchdog counter
	logic [9:0] since_irq_r;   // Zero while no irq point is pending

	// Checker helper; restart, time-out and reset clear it
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			since_irq_r <= 10'h000;
		else if (clk_en)
		begin
			if (restart || hit_full)
				since_irq_r <= 10'h000;
			else if (hit_irq)
				since_irq_r <= 10'h001;
			else if (since_irq_r != 10'h000 && since_irq_r != 10'h3FF)
				since_irq_r <= since_irq_r + 10'h001;
		end
	end

	AST_GAP_512: assert property (
		clk_en && hit_full && !restart && since_irq_r != 10'h000
		|-> since_irq_r == `CWDT_RST_GAP)
		else $error("reset point not 512 clocks after irq point");

	AST_FULL_TIMEOUT: assert property (
		clk_en && hit_full && !restart |=> rst_flag_r && cnt_r == '0)
		else $error("time-out did not set reset flag and clear counter");

	AST_CPU_RST: assert property (
		clk_en && hit_full && !restart && rst_en_r |=> wdog_cpu_rst)
		else $error("enabled time-out gave no processor reset");

	AST_NO_CPU_RST: assert property (
		wdog_cpu_rst |-> $past(rst_en_r) && $past(hit_full))
		else $error("processor reset without enable or time-out");

	// Counter is 0 one edge after the restart and 1 the edge after
	AST_RESTART: assert property (
		clk_en && restart ##1 clk_en [*2] |-> cnt_r == 1 && !rst_flag_r
		|| $past(rst_flag_r, 2))
		else $error("restart did not begin a new interval");

	AST_COUNT_UP: assert property (
		clk_en && !restart && !hit_full |=> cnt_r == $past(cnt_r) + 1)
		else $error("counter did not advance");

	AST_IRQ_REQ: assert property (
		wdog_irq |-> $past(irq_en) && $past(irq_flag_r))
		else $error("irq request without flag and enable");

	AST_FLAG_STICKY: assert property (
		irq_flag_r && !(clk_en && clr_irq) |=> irq_flag_r)
		else $error("irq flag dropped without a clear");

	AST_FREEZE: assert property (!clk_en |=> $stable(cnt_r))
		else $error("counter moved with clock enable low");

endmodule // cwdt_top

/* rtl/cwdt_defs.svh */
/*
 * Constants of the crystal watchdog timer: register offsets, field
 * positions, reset values, unlock keys and timing counts.
 * Assumes an 8-bit register port with byte offsets as addresses.
 */
// Behaviour
// - Counter runs freely on every crystal clock with clk_en high
// - Select picks 2^17, 2^20, 2^23, 2^26 counts
// - Exactly 512 clocks between irq flag and reset
// - Irq flag sets at interrupt count, enabled or not
// - Reset flag sets at full count, stays readable
// - Reset enable one resets processor at time-out
// - Restart bit restarts counter for full interval
// - Reset enable and restart need timed unlock
// - AAh then 55h to C7h opens three cycles
// - Irq request only when enabled and flagged
// - Irq enable and reset enable act independently
// - Time-out select sits at clock bits 7:6
// - Enabled watchdog irq wakes the processor
// - Time counted in crystal clock periods only
`ifndef CWDT_DEFS_SVH
`define CWDT_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define CWDT_OFS_CLK_SPEED     8'h8E
`define CWDT_OFS_TIMED_ACCESS  8'hC7
`define CWDT_OFS_WDOG_CTRL     8'hD8
`define CWDT_OFS_EXT_IRQ_EN    8'hE8

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CWDT_BIT_SEL_HI        7
`define CWDT_BIT_SEL_LO        6
`define CWDT_BIT_IRQ_FLAG      3
`define CWDT_BIT_RST_FLAG      2
`define CWDT_BIT_RST_EN        1
`define CWDT_BIT_RESTART       0
`define CWDT_BIT_IRQ_EN        4

// ----------------------------------------------------------------
// Reset values and keys
// ----------------------------------------------------------------
`define CWDT_RST_CLK_SPEED     8'h00
`define CWDT_RST_EXT_IRQ_EN    8'h00
`define CWDT_RST_RST_EN        1'h0
`define CWDT_UNLOCK_KEY1       8'hAA
`define CWDT_UNLOCK_KEY2       8'h55

// ----------------------------------------------------------------
// Timing counts, in crystal clocks
// ----------------------------------------------------------------
`define CWDT_RST_GAP           10'h200
`define CWDT_WIN_CYCLES        2'h3

`endif

/* rtl/cwdt_pkg.sv */
/*
 * Types shared by the crystal watchdog timer modules.
 * Assumes the constants header is included by each module.
 */
package cwdt_pkg;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	// Time-out select code
	typedef logic [1:0] cwdt_sel_t;

	// Timed access unlock states
	typedef enum logic [1:0] {
		UNL_IDLE,
		UNL_ARMED,
		UNL_OPEN
	} cwdt_unl_t;

endpackage

/* rtl/cwdt_unlock.sv */
/*
 * Timed access unlock of the crystal watchdog timer.
 * Assumes single-cycle write strobes on the same clock as the top.
 */
`timescale 1ns/10ps
`include "cwdt_defs.svh"

module cwdt_unlock
	import cwdt_pkg::*;
(
	input  wire logic       ref_clk,   // Crystal clock
	input  wire logic       sys_rst,   // Synchronous reset, high
	input  wire logic       clk_en,    // Freezes state when low
	input  wire logic       wr_any,    // Any register write
	input  wire logic       ta_wr,     // Write to timed access reg
	input  wire logic [7:0] wdata,     // Write data
	input  wire logic       prot_wr,   // Protected register write
	output logic            win_open   // Protected write allowed
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	cwdt_unl_t  state_r;   // Unlock state
	logic [1:0] win_r;     // Cycles left in window

	assign win_open = (state_r == UNL_OPEN);

	// Key sequence; a repeated first key re-arms, any other write breaks it
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			state_r <= UNL_IDLE;
		else if (clk_en)
		begin
			unique case (state_r)
				UNL_IDLE:
					if (ta_wr && wdata == `CWDT_UNLOCK_KEY1)
						state_r <= UNL_ARMED;
				UNL_ARMED:
					if (ta_wr && wdata == `CWDT_UNLOCK_KEY2)
						state_r <= UNL_OPEN;
					else if (ta_wr && wdata == `CWDT_UNLOCK_KEY1)
						state_r <= UNL_ARMED;
					else if (wr_any)
						state_r <= UNL_IDLE;
				UNL_OPEN:
					// One protected write, or timeout, closes it
					if (prot_wr || win_r == 2'h1)
						state_r <= UNL_IDLE;
			endcase
		end
	end

	// Window length counter
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			win_r <= 2'h0;
		else if (clk_en)
		begin
			if (state_r == UNL_ARMED && ta_wr && wdata == `CWDT_UNLOCK_KEY2)
				win_r <= `CWDT_WIN_CYCLES;
			else if (win_r != 2'h0)
				win_r <= win_r - 2'h1;
		end
	end

endmodule // cwdt_unlock

/* verification/cwdt_cpu_model.sv */
/*
 * Processor-side model: the core's reset and interrupt inputs.
 * Assumes the watchdog's requests are sampled on ref_clk.
 */
`timescale 1ns/10ps

module cwdt_cpu_model (
	input  wire logic ref_clk,      // Crystal clock
	input  wire logic wdog_irq,     // Interrupt request
	input  wire logic wdog_wake,    // Wake request
	input  wire logic wdog_cpu_rst, // Reset request pulse
	output int        rst_cnt,      // Resets taken by the core
	output int        irq_cnt       // Interrupt entries taken
);
	logic irq_d_r;                  // Last sampled irq or wake

	// ------------------------------------------------------------
	// Counting of taken resets and interrupts
	// ------------------------------------------------------------
	initial
	begin
		rst_cnt = 0;
		irq_cnt = 0;
		irq_d_r = 1'b0;
	end

	// Core resets on every pulse; enters the handler on a new request
	always @(posedge ref_clk)
	begin
		irq_d_r <= wdog_irq | wdog_wake;
		if (wdog_cpu_rst === 1'b1)
			rst_cnt <= rst_cnt + 1;
		if ((wdog_irq | wdog_wake) === 1'b1 && irq_d_r !== 1'b1)
			irq_cnt <= irq_cnt + 1;
	end
endmodule // cwdt_cpu_model

/* verification/cwdt_tb.sv */
/*
 * Self-checking bench of the crystal watchdog timer.
 * Assumes shortened count exponents and the processor model.
 */
`timescale 1ns/10ps
`include "cwdt_defs.svh"

module testbench
	import cwdt_pkg::*;
;
	localparam int         EXP [4] = '{4, 5, 6, 7}; // Short exponents
	localparam int         GAP     = 512;           // Irq flag to reset
	localparam logic [7:0] A_CLK   = `CWDT_OFS_CLK_SPEED;
	localparam logic [7:0] A_TA    = `CWDT_OFS_TIMED_ACCESS;
	localparam logic [7:0] A_CTL   = `CWDT_OFS_WDOG_CTRL;
	localparam logic [7:0] A_IEN   = `CWDT_OFS_EXT_IRQ_EN;

	logic       ref_clk;      // Crystal clock
	logic       sys_rst;      // Reset
	logic       clk_en;       // Clock enable
	logic [7:0] reg_addr;     // Register address
	logic [7:0] reg_wdata;    // Write data
	logic       reg_wr;       // Write strobe
	logic       reg_rd;       // Read strobe
	logic [7:0] reg_rdata;    // Read data
	logic       wdog_irq;     // Interrupt request
	logic       wdog_wake;    // Wake request
	logic       wdog_cpu_rst; // Reset pulse
	int         rst_cnt;      // Resets seen by the core
	int         irq_cnt;      // Interrupts seen by the core
	int         bad_count;    // Mismatches
	int         cmp_count;    // Comparisons
	int         n;            // Measured cycles
	int         r0;           // Reset count snapshot
	int         i0;           // Irq count snapshot

	cwdt_top #(.EXP_00(EXP[0]), .EXP_01(EXP[1]), .EXP_10(EXP[2]), .EXP_11(EXP[3])) DUT (
		.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .wdog_irq(wdog_irq),
		.wdog_wake(wdog_wake), .wdog_cpu_rst(wdog_cpu_rst));

	cwdt_cpu_model cpu (
		.ref_clk(ref_clk), .wdog_irq(wdog_irq), .wdog_wake(wdog_wake),
		.wdog_cpu_rst(wdog_cpu_rst), .rst_cnt(rst_cnt), .irq_cnt(irq_cnt));

	// ------------------------------------------------------------
	// Bus tasks and comparison
	// ------------------------------------------------------------
	task give_verdict();
		if (bad_count == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("Error %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	// One-cycle write strobe, taken at the second edge
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge ref_clk);
		reg_wr    <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task chk_rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e, input string w);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge ref_clk);
		reg_rd   <= 1'b0;
		#1;
		check(w, 32'(reg_rdata & m), 32'(e));
	endtask

	// Unlock keys, then the protected control write right after
	task prot(input logic [7:0] d);
		wr(A_TA, `CWDT_UNLOCK_KEY1);
		wr(A_TA, `CWDT_UNLOCK_KEY2);
		wr(A_CTL, d);
	endtask

	// Cycles until irq (sel 0) or reset pulse (sel 1), bounded
	task wait_out(input logic sel, output int k);
		k = 0;
		do
		begin
			@(posedge ref_clk);
			#1;
			k++;
		end while (((sel ? wdog_cpu_rst : wdog_irq) !== 1'b1) && k < 2000);
		if (k >= 2000)
		begin
			bad_count++;
			give_verdict();
		end
	endtask

	// ------------------------------------------------------------
	// Clock and main sequence
	// ------------------------------------------------------------
	initial
	begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	initial
	begin
		bad_count = 0;
		cmp_count = 0;
		sys_rst   <= 1'b1;
		clk_en    <= 1'b1;
		reg_addr  <= 8'h00;
		reg_wdata <= 8'h00;
		reg_wr    <= 1'b0;
		reg_rd    <= 1'b0;
		repeat (20) @(posedge ref_clk);
		sys_rst <= 1'b0;
		// Reset values, key register and an unmapped place
		chk_rd(A_CTL, 8'hFF, 8'h00, "ctl reset");
		chk_rd(A_CLK, 8'hFF, 8'h00, "clk reset");
		chk_rd(A_IEN, 8'hFF, 8'h00, "ien reset");
		chk_rd(A_TA, 8'hFF, 8'h00, "key read");
		wr(8'h10, 8'hFF);
		chk_rd(8'h10, 8'hFF, 8'h00, "unmapped");
		wr(A_CLK, 8'h3F);
		chk_rd(A_CLK, 8'hFF, 8'h3F, "clk rw");
		wr(A_IEN, 8'hEF);
		chk_rd(A_IEN, 8'hFF, 8'hEF, "ien rw");
		// Every time-out select, irq and reset enabled
		wr(A_IEN, 8'h10);
		r0 = rst_cnt;
		for (int s = 0; s < 4; s++)
		begin
			prot(8'h01);
			wr(A_CLK, {2'(s), 6'h00});
			wr(A_CTL, 8'h00);
			prot(8'h03);
			wait_out(1'b0, n);
			check("irq delay", n, (1 << EXP[s]) + 1);
			check("wake", 32'(wdog_wake), 1);
			wait_out(1'b1, n);
			check("reset gap", n, GAP - 1);
			@(posedge ref_clk);
			#1;
			check("reset pulse", 32'(wdog_cpu_rst), 0);
			chk_rd(A_CTL, 8'hFF, 8'h0E, "flags");
		end
		check("resets taken", rst_cnt - r0, 4);
		// Restart between the flags postpones the reset
		wr(A_CTL, 8'h00);
		prot(8'h03);
		wait_out(1'b0, n);
		prot(8'h0F);
		chk_rd(A_CTL, 8'h08, 8'h08, "irq kept");
		// Two cycles of the interval went to the flag read
		wait_out(1'b1, n);
		check("cancel", n, (1 << EXP[3]) + GAP - 2);
		chk_rd(A_CTL, 8'hFF, 8'h0E, "flags again");
		// Protected bits refuse writes outside the window
		wr(A_CTL, 8'h00);
		chk_rd(A_CTL, 8'h02, 8'h02, "no unlock");
		wr(A_TA, `CWDT_UNLOCK_KEY1);
		wr(8'h10, 8'h00);
		wr(A_TA, `CWDT_UNLOCK_KEY2);
		wr(A_CTL, 8'h00);
		chk_rd(A_CTL, 8'h02, 8'h02, "broken keys");
		wr(A_TA, `CWDT_UNLOCK_KEY1);
		wr(A_TA, `CWDT_UNLOCK_KEY2);
		repeat (4) @(posedge ref_clk);
		wr(A_CTL, 8'h00);
		chk_rd(A_CTL, 8'h02, 8'h02, "late write");
		prot(8'h00);
		chk_rd(A_CTL, 8'h02, 8'h00, "unlocked");
		// Both enables off: flags still set, core left alone
		wr(A_IEN, 8'h00);
		wr(A_CTL, 8'h00);
		prot(8'h01);
		r0 = rst_cnt;
		i0 = irq_cnt;
		repeat (700) @(posedge ref_clk);
		check("no reset", rst_cnt - r0, 0);
		check("no irq", irq_cnt - i0, 0);
		chk_rd(A_CTL, 8'hFF, 8'h0C, "flags alone");
		wr(A_IEN, 8'h10);
		@(posedge ref_clk);
		#1;
		check("late enable", 32'(wdog_irq), 1);
		// Clock enable low for 50 cycles holds the count back
		wr(A_CTL, 8'h00);
		prot(8'h01);
		clk_en <= 1'b0;
		repeat (50) @(posedge ref_clk);
		clk_en <= 1'b1;
		wait_out(1'b0, n);
		check("frozen", n, (1 << EXP[3]) + 1);
		// Reset in mid-run clears flags and enables
		@(posedge ref_clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		sys_rst <= 1'b0;
		chk_rd(A_CTL, 8'hFF, 8'h00, "ctl rerun");
		check("irq rerun", 32'(wdog_irq), 0);
		chk_rd(A_IEN, 8'hFF, 8'h00, "ien rerun");
		give_verdict();
	end
endmodule // testbench
